// ### sim/ifb_src_model.sv
// peripheral interrupt source model facing the flag bank
// assumes one-cycle pulse commands from the bench on the bank clock
`timescale 1ns/1ps
`default_nettype none
module ifb_src_model
  import ifb_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  // commands from the bench
  input  wire logic [FLAG7_W-1:0] pulse_in,
  input  wire logic [SRC_W-1:0]   ext_val_in,
  // source levels to the bank
  output logic      [FLAG7_W-1:0] src_out,
  output logic      [SRC_W-1:0]   ext_out
);
  logic [FLAG7_W-1:0] hold_r;
  logic [2:0]         cnt_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r  <= '0;
      cnt_r   <= 3'h0;
      ext_out <= '0;
    end else begin
      ext_out <= ext_val_in;
      if (pulse_in != '0) begin
        hold_r <= pulse_in;
        cnt_r  <= 3'h4;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  assign src_out = (cnt_r != 3'h0) ? hold_r : '0;
endmodule : ifb_src_model
`default_nettype wire

// ### sim/test_ifb_bank.sv
// self-checking bench for the flag and enable bank
// assumes the source model and the package are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ifb_bank
  import ifb_pkg::*;
;
  logic               ref_clk_in;
  logic               rst_n_in;
  ifb_wb_req_t        req;
  ifb_wb_rsp_t        rsp;
  logic [FLAG7_W-1:0] pulse, src, f7en, f7req;
  logic [SRC_W-1:0]   ext_val, ext, core_req;
  logic               irq;
  logic [31:0]        rs, rd, m_f7, m_en0, m_en1, m_sts, m_sen;
  int                 n_fail, cmp_count;

  ifb_src_model u_ifb_src_model (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pulse_in(pulse), .ext_val_in(ext_val), .src_out(src), .ext_out(ext));
  ifb_bank u_ifb_bank (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wb_req_in(req),
    .wb_rsp_out(rsp), .flag7_src_in(src), .flag7_en_in(f7en), .ext_flags_in(ext),
    .core_req_out(core_req), .flag7_req_out(f7req), .irq_out(irq));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // classic single cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (rsp.ack !== 1'b1);
    chk("ack_wait", 32'(n), 32'd2);
    rd = rsp.dat;
    req <= '0;
    @(posedge ref_clk_in);
  endtask : wb

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = o;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r & m;
  endfunction : mrg

  // bench register model, byte lanes honoured except on event clear
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, a, s, d);
    case (a)
      OFS_FLAGS7:  m_f7 = mrg(m_f7, d, s, {16'h0, FLAGS7_MASK});
      OFS_EN0:     m_en0 = mrg(m_en0, d, s, {16'h0, EN0_MASK});
      OFS_EN1:     m_en1 = mrg(m_en1, d, s, {16'h0, EN1_MASK});
      OFS_EVT_CLR: m_sts = m_sts & ~(d & 32'h3f);
      OFS_EVT_EN:  m_sen = mrg(m_sen, d, s, 32'h3f);
      default: ;
    endcase
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk

  task automatic rall();
    rchk("flags7", OFS_FLAGS7, m_f7);
    rchk("en0", OFS_EN0, m_en0);
    rchk("en1", OFS_EN1, m_en1);
    rchk("evt_sts", OFS_EVT_STS, m_sts);
    rchk("evt_en", OFS_EVT_EN, m_sen);
    rchk("unmapped", 8'h18, 32'h0);
  endtask : rall

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    results();
  end

  initial begin
    rs = 32'ha714ab5b;
    {n_fail, cmp_count} = '0;
    {m_f7, m_en0, m_en1, m_sts, m_sen} = '0;
    {req, pulse, f7en, ext_val} = '0;
    rst_n_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rall();
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      wr(OFS_FLAGS7, (i < 6) ? 4'hf : 4'(i), rnd());
      wr(OFS_EN0, (i < 6) ? 4'hf : 4'(i), rnd());
      wr(OFS_EN1, 4'hf, (i == 0) ? 32'hffff_ffff : rnd());
      wr(OFS_EVT_STS, 4'hf, rnd());
      ext_val <= rnd();
      repeat (3) @(posedge ref_clk_in);
      rall();
      chk("core_req", core_req, ext_val & {m_en1[15:0], m_en0[15:0]});
    end
    $display("test registers done");
    // each source sets its own flag
    for (int b = 0; b < FLAG7_W; b++) begin
      wr(OFS_FLAGS7, 4'hf, 32'h0);
      wr(OFS_EVT_CLR, 4'hf, 32'h3f);
      wr(OFS_EVT_EN, 4'hf, 32'h1 << b);
      f7en <= 6'(rnd());
      pulse <= 6'h1 << b;
      @(posedge ref_clk_in);
      pulse <= '0;
      repeat (8) @(posedge ref_clk_in);
      m_f7 = 32'h1 << b;
      m_sts = m_f7;
      chk("flag7_req", {26'h0, f7req}, m_f7 & {26'h0, f7en});
      chk("irq", {31'h0, irq}, 32'h1);
      rall();
      wr(OFS_EVT_EN, 4'hf, 32'h0);
      repeat (2) @(posedge ref_clk_in);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(OFS_EVT_EN, 4'hf, 32'h3f);
      repeat (2) @(posedge ref_clk_in);
      chk("irq_again", {31'h0, irq}, 32'h1);
      wr(OFS_EVT_CLR, 4'hf, 32'h1 << b);
      repeat (2) @(posedge ref_clk_in);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      rall();
    end
    $display("test sources done");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    {m_f7, m_en0, m_en1, m_sts, m_sen} = '0;
    @(posedge ref_clk_in);
    rall();
    chk("core_req_rst", core_req, 32'h0);
    chk("irq_rst", {31'h0, irq}, 32'h0);
    chk("flag7_req_rst", {26'h0, f7req}, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule : test_ifb_bank
`default_nettype wire

// ### src/ifb_bank.sv
// interrupt flag word 7 and enable words 0 and 1, wishbone slave
// assumes a classic single-cycle wishbone master on the same clock;
// word 7 sources may be asynchronous, other flag inputs are local logic
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - unimplemented bits read zero, ignore writes
// - flag set by source, software may write
// - flag bit 5 latches scan controller
// - serial six sets bits four, three, two
// - enable one permits, zero blocks request
// - enable word zero upper byte assignments
// - enable word zero lower byte assignments
// - enable word one upper byte assignments
// - capcmp six, five, hole, external one
// - power-on reset clears all bits
// - enable word one low nibble gating
module ifb_bank
  import ifb_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  // wishbone slave
  input  wire ifb_wb_req_t        wb_req_in,
  output ifb_wb_rsp_t             wb_rsp_out,
  // word 7 interrupt sources, asynchronous
  input  wire logic [FLAG7_W-1:0] flag7_src_in,
  // enables for word 7 sources, held elsewhere
  input  wire logic [FLAG7_W-1:0] flag7_en_in,
  // flags for enable words 0 (low half) and 1 (high half)
  input  wire logic [SRC_W-1:0]   ext_flags_in,
  // gated requests to the core
  output logic      [SRC_W-1:0]   core_req_out,
  output logic      [FLAG7_W-1:0] flag7_req_out,
  // bank event interrupt
  output logic                    irq_out
);

  // ----------------------------------------------------------------
  // source synchronisation and edge detect
  // ----------------------------------------------------------------
  logic [FLAG7_W-1:0] src_sync;
  logic [FLAG7_W-1:0] src_prev_r;
  logic [FLAG7_W-1:0] src_prev_nxt;
  logic [FLAG7_W-1:0] hw_set;

  ifb_sync #(
    .WIDTH (FLAG7_W)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (flag7_src_in),
    .sync_out   (src_sync)
  );

  always_comb begin
    src_prev_nxt = src_sync;
    hw_set       = src_sync & ~src_prev_r;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_prev_r <= EVT_RST;
    end else begin
      src_prev_r <= src_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic              ack_r;
  logic              ack_nxt;
  logic [DATA_W-1:0] rdat_r;
  logic [DATA_W-1:0] rdat_nxt;
  logic              access;
  logic              wr;
  logic [REG_W-1:0]  wmask;

  always_comb begin
    access = wb_req_in.cyc & wb_req_in.stb & ~ack_r;
    wr     = access & wb_req_in.we;
    wmask  = {{8{wb_req_in.sel[1]}}, {8{wb_req_in.sel[0]}}};
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [REG_W-1:0]   flags7_r;
  logic [REG_W-1:0]   flags7_nxt;
  logic [REG_W-1:0]   en0_r;
  logic [REG_W-1:0]   en0_nxt;
  logic [REG_W-1:0]   en1_r;
  logic [REG_W-1:0]   en1_nxt;
  logic [FLAG7_W-1:0] evt_sts_r;
  logic [FLAG7_W-1:0] evt_sts_nxt;
  logic [FLAG7_W-1:0] evt_en_r;
  logic [FLAG7_W-1:0] evt_en_nxt;
  logic [REG_W-1:0]   wval;

  always_comb begin
    flags7_nxt  = flags7_r;
    en0_nxt     = en0_r;
    en1_nxt     = en1_r;
    evt_sts_nxt = evt_sts_r;
    evt_en_nxt  = evt_en_r;
    wval        = wb_req_in.dat[REG_W-1:0];
    if (wr) begin
      unique case (wb_req_in.adr)
        OFS_FLAGS7:  flags7_nxt = (flags7_r & ~wmask) | (wval & wmask);
        OFS_EN0:     en0_nxt = (en0_r & ~wmask) | (wval & wmask);
        OFS_EN1:     en1_nxt = (en1_r & ~wmask) | (wval & wmask);
        OFS_EVT_CLR: evt_sts_nxt = evt_sts_r & ~(wval[FLAG7_W-1:0] & wmask[FLAG7_W-1:0]);
        OFS_EVT_EN:  evt_en_nxt = (evt_en_r & ~wmask[FLAG7_W-1:0])
                                  | (wval[FLAG7_W-1:0] & wmask[FLAG7_W-1:0]);
        default:     flags7_nxt = flags7_r;
      endcase
    end
    flags7_nxt[FLAG7_W-1:0] = flags7_nxt[FLAG7_W-1:0] | hw_set;
    evt_sts_nxt             = evt_sts_nxt | hw_set;
    flags7_nxt = flags7_nxt & FLAGS7_MASK;
    en0_nxt    = en0_nxt & EN0_MASK;
    en1_nxt    = en1_nxt & EN1_MASK;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags7_r  <= REG_RST;
      en0_r     <= REG_RST;
      en1_r     <= REG_RST;
      evt_sts_r <= EVT_RST;
      evt_en_r  <= EVT_RST;
    end else begin
      flags7_r  <= flags7_nxt;
      en0_r     <= en0_nxt;
      en1_r     <= en1_nxt;
      evt_sts_r <= evt_sts_nxt;
      evt_en_r  <= evt_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read path and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    ack_nxt  = access;
    rdat_nxt = RD_ZERO;
    if (access && !wb_req_in.we) begin
      unique case (wb_req_in.adr)
        OFS_FLAGS7:  rdat_nxt = {{(DATA_W-REG_W){1'b0}}, flags7_r};
        OFS_EN0:     rdat_nxt = {{(DATA_W-REG_W){1'b0}}, en0_r};
        OFS_EN1:     rdat_nxt = {{(DATA_W-REG_W){1'b0}}, en1_r};
        OFS_EVT_STS: rdat_nxt = {{(DATA_W-FLAG7_W){1'b0}}, evt_sts_r};
        OFS_EVT_EN:  rdat_nxt = {{(DATA_W-FLAG7_W){1'b0}}, evt_en_r};
        default:     rdat_nxt = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r  <= 1'b0;
      rdat_r <= RD_ZERO;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_rsp_out = '{ack: ack_r, dat: rdat_r};

  // ----------------------------------------------------------------
  // request gating to the core
  // ----------------------------------------------------------------
  logic [SRC_W-1:0]   core_req_r;
  logic [SRC_W-1:0]   core_req_nxt;
  logic [FLAG7_W-1:0] f7_req_r;
  logic [FLAG7_W-1:0] f7_req_nxt;
  logic               irq_r;
  logic               irq_nxt;

  always_comb begin
    core_req_nxt = ext_flags_in & {en1_r, en0_r};
    f7_req_nxt   = flags7_r[FLAG7_W-1:0] & flag7_en_in;
    irq_nxt      = |(evt_sts_r & evt_en_r);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_req_r <= '0;
      f7_req_r   <= EVT_RST;
      irq_r      <= 1'b0;
    end else begin
      core_req_r <= core_req_nxt;
      f7_req_r   <= f7_req_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign core_req_out  = core_req_r;
  assign flag7_req_out = f7_req_r;
  assign irq_out       = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic started_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
    end
  end

  property p_holes_zero;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (ack_r && $past(!wb_req_in.we) && $past(wb_req_in.adr) == OFS_FLAGS7)
      |-> (rdat_r[DATA_W-1:FLAG7_W] == '0 && en1_r[BIT_EN1_HOLE] == 1'b0);
  endproperty
  a_holes_zero: assert property (p_holes_zero)
    else $error("unimplemented bit not zero");

  property p_hw_set;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (|hw_set) |=> ((flags7_r[FLAG7_W-1:0] & $past(hw_set)) == $past(hw_set));
  endproperty
  a_hw_set: assert property (p_hw_set)
    else $error("flag not set by source");

  property p_scan_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(src_sync[BIT_SCAN_CTRL]) |=> flags7_r[BIT_SCAN_CTRL] && evt_sts_r[BIT_SCAN_CTRL];
  endproperty
  a_scan_flag: assert property (p_scan_flag)
    else $error("scan controller flag missed");

  property p_serial6;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(flag7_src_in[BIT_SER6_ERR]) ##2 $rose(src_sync[BIT_SER6_ERR])
      |=> flags7_r[BIT_SER6_ERR];
  endproperty
  a_serial6: assert property (p_serial6)
    else $error("serial six error flag missed");

  property p_serial5;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      hw_set[BIT_SER5_TX] |=> flags7_r[BIT_SER5_TX] && evt_sts_r[BIT_SER5_TX];
  endproperty
  a_serial5: assert property (p_serial5)
    else $error("serial five transmit flag missed");

  property p_gate;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      started_r |=> core_req_r == ($past(ext_flags_in) & $past({en1_r, en0_r}));
  endproperty
  a_gate: assert property (p_gate)
    else $error("core request not flag and enable");

  property p_block;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !en0_r[BIT_EXT_IRQ0] |=> !core_req_r[BIT_EXT_IRQ0];
  endproperty
  a_block: assert property (p_block)
    else $error("disabled request forwarded");

  property p_en0_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (wr && wb_req_in.adr == OFS_EN0 && wb_req_in.sel[1:0] == 2'h3 && !(|hw_set))
      |=> en0_r == $past(wb_req_in.dat[REG_W-1:0]);
  endproperty
  a_en0_write: assert property (p_en0_write)
    else $error("enable word zero write lost");

  property p_en1_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (wr && wb_req_in.adr == OFS_EN1 && wb_req_in.sel[1:0] == 2'h3)
      |=> en1_r == ($past(wb_req_in.dat[REG_W-1:0]) & EN1_MASK);
  endproperty
  a_en1_write: assert property (p_en1_write)
    else $error("enable word one write wrong");

  property p_reset_clear;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !started_r |-> (flags7_r == REG_RST && en0_r == REG_RST && en1_r == REG_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("register not clear after reset");

  property p_low_nibble;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (en1_r[BIT_I2C1_SLAVE] && ext_flags_in[REG_W + BIT_I2C1_SLAVE])
      |=> core_req_r[REG_W + BIT_I2C1_SLAVE];
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("i2c slave request not forwarded");

  property p_ack_pulse;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ack_r |=> !ack_r;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_irq_out;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (|(evt_sts_r & evt_en_r)) |=> irq_r;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("event interrupt not raised");

  c_flag_set: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(flags7_r[BIT_SCAN_CTRL]));
  c_fwd: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(core_req_r[BIT_FLASH_DONE]));
  c_irq: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(irq_r));
  c_set_vs_clr: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr && wb_req_in.adr == OFS_FLAGS7 && (|hw_set));

endmodule : ifb_bank
`default_nettype wire

// ### src/ifb_pkg.sv
// package for the interrupt flag and enable bank
// assumes a 32-bit classic wishbone master and a single 20 MHz clock
package ifb_pkg;

  // ----------------------------------------------------------------
  // bus and register geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned FLAG7_W   = 6;
  localparam int unsigned SRC_W     = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FLAGS7  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EN0     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EN1     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_STS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_EN  = 8'h14;

  // ----------------------------------------------------------------
  // implemented bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]   FLAGS7_MASK = 16'h003f;
  localparam logic [REG_W-1:0]   EN0_MASK    = 16'hffff;
  localparam logic [REG_W-1:0]   EN1_MASK    = 16'hffdf;
  localparam logic [REG_W-1:0]   REG_RST     = 16'h0000;
  localparam logic [FLAG7_W-1:0] EVT_RST     = 6'h00;
  localparam logic [DATA_W-1:0]  RD_ZERO     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_SCAN_CTRL  = 5;
  localparam int unsigned BIT_SER6_ERR   = 4;
  localparam int unsigned BIT_SER6_TX    = 3;
  localparam int unsigned BIT_SER6_RX    = 2;
  localparam int unsigned BIT_SER5_ERR   = 1;
  localparam int unsigned BIT_SER5_TX    = 0;
  localparam int unsigned BIT_FLASH_DONE = 15;
  localparam int unsigned BIT_EXT_IRQ0   = 0;
  localparam int unsigned BIT_SER2_TX    = 15;
  localparam int unsigned BIT_CAPCMP6    = 7;
  localparam int unsigned BIT_CAPCMP5    = 6;
  localparam int unsigned BIT_EN1_HOLE   = 5;
  localparam int unsigned BIT_EXT_IRQ1   = 4;
  localparam int unsigned BIT_I2C1_SLAVE = 0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat;
  } ifb_wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } ifb_wb_rsp_t;

endpackage : ifb_pkg

// ### src/ifb_sync.sv
// two-flop level synchroniser, one per bit
// assumes inputs may change at any time relative to the clock
`timescale 1ns/1ps
`default_nettype none
module ifb_sync #(
  parameter int unsigned WIDTH = 6
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= async_in;
      hold_r <= meta_r;
    end
  end

  assign sync_out = hold_r;

endmodule : ifb_sync
`default_nettype wire
